/* rms_relay_seq.sv */
/*
 Relay output controller: time proportional, intermittent sampling with
 proportional blowdown, and manual mode with on and off delays.
 Assumes sensor readings and selector inputs synchronous to ref_clk_i.
*/
// Implementation choices: the register addresses and the address-and-strobe port.
// Functional notes
// - Time proportional: reading at set point keeps relay off all period.
// - Time proportional: reading one band off keeps relay on all period.
// - Time proportional reports on-time percent and position in period.
// - Intermittent sampling only allowed while heating/cooling modes on.
// - Each sampling cycle opens the valve for the sample time first.
// - Trapping on: close valve for hold time, read the trapped sample.
// - Trapped reading below set point: no blowdown, wait instead.
// - Trapped blowdown time scales with excess, maximum at full band.
// - Sample below set point: valve closed for wait time, then resample.
// - Trapping off: valve open untimed until reading drops below set point minus deadband.
// - Trapping off: relay drops once reading is deadband below set point.
// - Trapping off: output time limit ends an untimed blowdown.
// - Later relay claiming our sensor in sampling mode forces us off.
// - Sampling mode reports current step and time left in it.
// - Manual relay energised only for hand selector or linked request.
// - Manual activation delayed by on delay; zero means immediate.
// - Manual deactivation delayed by off delay; zero means immediate.
`timescale 1ns/1ps
`default_nettype none

module rms_relay_seq #(
   parameter int TICK_CYCLES = rms_pkg::RMS_TICK_CYCLES
)(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire rms_pkg::rms_bus_s bus_i,
   output logic [31:0] rd_data_o,
   input wire logic [15:0] sensor0_i,
   input wire logic [15:0] sensor1_i,
   input wire logic [1:0] hand_off_auto_selector_i,
   input wire logic link_activate_i,
   input wire logic claim_i,
   input wire logic claim_sensor_i,
   output logic relay_o,
   output rms_pkg::rms_status_s status_o
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      rms_pkg::rms_mode_e mode;
      logic dir;
      logic trap;
      logic hvac;
      logic sel;
      logic [15:0] sp;
      logic [15:0] pb;
      logic [15:0] db;
      logic [15:0] per;
      logic [15:0] st;
      logic [15:0] ht;
      logic [15:0] mbt;
      logic [15:0] wt;
      logic [15:0] lim;
      logic [15:0] ond;
      logic [15:0] offd;
      logic [31:0] rdata;
      rms_pkg::rms_step_e step;
      logic [15:0] rem;
      logic [15:0] lcnt;
      logic [15:0] pos;
      logic [6:0] pct;
      logic relay;
      logic [15:0] dcnt;
      logic [31:0] tcnt;
   } rms_state_s;

   rms_state_s s_q;
   rms_state_s s_d;
   logic tick;
   logic [15:0] rd;
   logic signed [16:0] err;
   logic signed [16:0] excess;
   logic auto_on;
   logic want;
   logic is_auto;

   // Linear scale of a deviation over a band, clamped to [0, full]
   function automatic logic [15:0] scale(input logic signed [16:0] e,
      input logic [15:0] band, input logic [15:0] full);
      logic [31:0] prod;
      prod = 32'h0000_0000;
      if (e <= 17'sd0)
      begin
         return 16'h0000;
      end
      if (e[15:0] >= band)
      begin
         return full;
      end
      prod = e[15:0] * full;
      return 16'(prod / {16'h0000, band});
   endfunction

   // ------------------------------------------------------------
   // Shared terms
   // ------------------------------------------------------------
   // One-second enable; the divider keeps the design on one clock
   assign tick = (s_q.tcnt == 32'(TICK_CYCLES - 1));
   assign rd = s_q.sel ? sensor1_i : sensor0_i;
   assign err = s_q.dir ? ($signed({1'b0, rd}) - $signed({1'b0, s_q.sp}))
                        : ($signed({1'b0, s_q.sp}) - $signed({1'b0, rd}));
   assign excess = $signed({1'b0, rd}) - $signed({1'b0, s_q.sp});
   assign is_auto = (hand_off_auto_selector_i == rms_pkg::RMS_HOA_AUTO);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.rdata = 32'h0000_0000;
      s_d.tcnt = tick ? 32'h0000_0000 : s_q.tcnt + 32'h0000_0001;
      auto_on = 1'b0;
      want = 1'b0;
      // Register writes; sampling mode is refused while hvac is off
      if (bus_i.we)
      begin
         case (bus_i.addr)
            rms_pkg::RMS_A_CTRL:
            begin
               s_d.mode = rms_pkg::rms_mode_e'(bus_i.wdata[1:0]);
               if (s_d.mode == rms_pkg::RMS_ISAMP && !bus_i.wdata[4])
               begin
                  s_d.mode = s_q.mode;
               end
               s_d.dir = bus_i.wdata[2];
               s_d.trap = bus_i.wdata[3];
               s_d.hvac = bus_i.wdata[4];
               s_d.sel = bus_i.wdata[5];
            end
            rms_pkg::RMS_A_SETPT: s_d.sp = bus_i.wdata[15:0];
            rms_pkg::RMS_A_PBAND: s_d.pb = bus_i.wdata[15:0];
            rms_pkg::RMS_A_DBAND: s_d.db = bus_i.wdata[15:0];
            rms_pkg::RMS_A_PERIOD: s_d.per = bus_i.wdata[15:0];
            rms_pkg::RMS_A_SAMPLE: s_d.st = bus_i.wdata[15:0];
            rms_pkg::RMS_A_HOLD: s_d.ht = bus_i.wdata[15:0];
            rms_pkg::RMS_A_MAXBD: s_d.mbt = bus_i.wdata[15:0];
            rms_pkg::RMS_A_WAIT: s_d.wt = bus_i.wdata[15:0];
            rms_pkg::RMS_A_LIMIT: s_d.lim = bus_i.wdata[15:0];
            rms_pkg::RMS_A_ONDLY: s_d.ond = bus_i.wdata[15:0];
            rms_pkg::RMS_A_OFFDLY: s_d.offd = bus_i.wdata[15:0];
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
      // Dropping hvac or losing the sensor to a later relay ends sampling
      if (s_d.mode == rms_pkg::RMS_ISAMP && (!s_d.hvac ||
          (claim_i && claim_sensor_i == s_d.sel)))
      begin
         s_d.mode = rms_pkg::RMS_OFF;
      end
      // Register reads, answered in the next cycle
      if (bus_i.re)
      begin
         case (bus_i.addr)
            rms_pkg::RMS_A_CTRL:
               s_d.rdata = {26'h000_0000, s_q.sel, s_q.hvac, s_q.trap,
                  s_q.dir, s_q.mode};
            rms_pkg::RMS_A_SETPT: s_d.rdata = {16'h0000, s_q.sp};
            rms_pkg::RMS_A_PBAND: s_d.rdata = {16'h0000, s_q.pb};
            rms_pkg::RMS_A_DBAND: s_d.rdata = {16'h0000, s_q.db};
            rms_pkg::RMS_A_PERIOD: s_d.rdata = {16'h0000, s_q.per};
            rms_pkg::RMS_A_SAMPLE: s_d.rdata = {16'h0000, s_q.st};
            rms_pkg::RMS_A_HOLD: s_d.rdata = {16'h0000, s_q.ht};
            rms_pkg::RMS_A_MAXBD: s_d.rdata = {16'h0000, s_q.mbt};
            rms_pkg::RMS_A_WAIT: s_d.rdata = {16'h0000, s_q.wt};
            rms_pkg::RMS_A_LIMIT: s_d.rdata = {16'h0000, s_q.lim};
            rms_pkg::RMS_A_ONDLY: s_d.rdata = {16'h0000, s_q.ond};
            rms_pkg::RMS_A_OFFDLY: s_d.rdata = {16'h0000, s_q.offd};
            rms_pkg::RMS_A_STATUS:
               s_d.rdata = {20'h0_0000, s_q.relay, s_q.step, 1'b0, s_q.pct};
            rms_pkg::RMS_A_POS: s_d.rdata = {16'h0000, s_q.pos};
            rms_pkg::RMS_A_REMAIN: s_d.rdata = {16'h0000, s_q.rem};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
      // Time proportional: percent is latched at each period start
      if (s_q.mode != rms_pkg::RMS_TPROP)
      begin
         s_d.pos = 16'h0000;
         s_d.pct = 7'(scale(err, s_q.pb, 16'(rms_pkg::RMS_PCT_FULL)));
      end
      else if (tick)
      begin
         if (s_q.pos + 16'h0001 >= s_q.per)
         begin
            s_d.pos = 16'h0000;
            s_d.pct = 7'(scale(err, s_q.pb, 16'(rms_pkg::RMS_PCT_FULL)));
         end
         else
         begin
            s_d.pos = s_q.pos + 16'h0001;
         end
      end
      // On while position share is below percent share: 0 % never, 100 %
      // always, so set point and full band hold for the whole period
      if (s_q.mode == rms_pkg::RMS_TPROP)
      begin
         auto_on = (32'(s_q.pos) * 32'h0000_0064)
                   < (32'(s_q.pct) * 32'(s_q.per));
      end
      // Intermittent sampling sequencer, only while automatic
      if (s_q.mode != rms_pkg::RMS_ISAMP || !is_auto)
      begin
         s_d.step = rms_pkg::ST_IDLE;
         s_d.rem = 16'h0000;
      end
      else
      begin
         if (tick && s_q.rem != 16'h0000)
         begin
            s_d.rem = s_q.rem - 16'h0001;
         end
         unique case (s_q.step)
            rms_pkg::ST_IDLE:
            begin
               s_d.step = rms_pkg::ST_SAMPLE;
               s_d.rem = s_q.st;
            end
            rms_pkg::ST_SAMPLE:
            begin
               if (s_q.rem == 16'h0000)
               begin
                  if (s_q.trap)
                  begin
                     s_d.step = rms_pkg::ST_HOLD;
                     s_d.rem = s_q.ht;
                  end
                  else if (rd < s_q.sp)
                  begin
                     s_d.step = rms_pkg::ST_WAIT;
                     s_d.rem = s_q.wt;
                  end
                  else
                  begin
                     s_d.step = rms_pkg::ST_FREE;
                     s_d.lcnt = 16'h0000;
                  end
               end
            end
            rms_pkg::ST_HOLD:
            begin
               if (s_q.rem == 16'h0000)
               begin
                  if (rd < s_q.sp)
                  begin
                     s_d.step = rms_pkg::ST_WAIT;
                     s_d.rem = s_q.wt;
                  end
                  else
                  begin
                     s_d.step = rms_pkg::ST_BLOW;
                     s_d.rem = scale(excess, s_q.pb, s_q.mbt);
                  end
               end
            end
            rms_pkg::ST_BLOW, rms_pkg::ST_WAIT:
            begin
               if (s_q.rem == 16'h0000)
               begin
                  s_d.step = rms_pkg::ST_SAMPLE;
                  s_d.rem = s_q.st;
               end
            end
            rms_pkg::ST_FREE:
            begin
               // Live reading is trusted here since the valve stays open
               if ({1'b0, rd} + {1'b0, s_q.db} < {1'b0, s_q.sp} ||
                   (s_q.lim != 16'h0000 && s_q.lcnt >= s_q.lim))
               begin
                  s_d.step = rms_pkg::ST_WAIT;
                  s_d.rem = s_q.wt;
               end
               else if (tick)
               begin
                  s_d.lcnt = s_q.lcnt + 16'h0001;
               end
            end
         endcase
         auto_on = (s_q.step == rms_pkg::ST_SAMPLE) ||
                   (s_q.step == rms_pkg::ST_BLOW) ||
                   (s_q.step == rms_pkg::ST_FREE);
      end
      // Relay drive; only manual mode applies the on and off delays
      if (s_q.mode == rms_pkg::RMS_MANUAL)
      begin
         want = (hand_off_auto_selector_i == rms_pkg::RMS_HOA_HAND) ||
                link_activate_i;
         if (want == s_q.relay)
         begin
            s_d.dcnt = 16'h0000;
         end
         else if ((want ? s_q.ond : s_q.offd) <= s_q.dcnt)
         begin
            s_d.relay = want;
            s_d.dcnt = 16'h0000;
         end
         else if (tick)
         begin
            s_d.dcnt = s_q.dcnt + 16'h0001;
         end
      end
      else
      begin
         if (s_q.mode != rms_pkg::RMS_OFF)
         begin
            want = (hand_off_auto_selector_i == rms_pkg::RMS_HOA_HAND) ||
                   (is_auto && auto_on);
         end
         s_d.relay = want;
         s_d.dcnt = 16'h0000;
      end
   end

   // ------------------------------------------------------------
   // Registers and outputs
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
         s_q.mode <= rms_pkg::RMS_RST_MODE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rd_data_o = s_q.rdata;
   assign relay_o = s_q.relay;
   assign status_o = {s_q.pct, s_q.pos, s_q.step, s_q.rem};

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   property p_tp_zero;
      s_q.mode == rms_pkg::RMS_TPROP && is_auto && s_q.pct == 7'h00
         |=> !relay_o;
   endproperty
   a_tp_zero: assert property (p_tp_zero)
      else $error("relay on at zero percent");

   property p_tp_full;
      s_q.mode == rms_pkg::RMS_TPROP && is_auto && s_q.pct == 7'h64
         && s_q.per != 16'h0000 |=> relay_o;
   endproperty
   a_tp_full: assert property (p_tp_full)
      else $error("relay off at full percent");

   property p_pct_range;
      s_q.pct <= 7'h64 && (s_q.mode != rms_pkg::RMS_TPROP ||
         s_q.per == 16'h0000 || s_q.pos < s_q.per);
   endproperty
   a_pct_range: assert property (p_pct_range)
      else $error("pct or pos bad");

   property p_hvac;
      s_q.mode == rms_pkg::RMS_ISAMP |-> s_q.hvac;
   endproperty
   a_hvac: assert property (p_hvac)
      else $error("sampling without hvac");

   property p_sample_on;
      s_q.mode == rms_pkg::RMS_ISAMP && s_q.step == rms_pkg::ST_SAMPLE
         && is_auto |=> relay_o;
   endproperty
   // Mode is checked too: a mode write leaves a stale step for one cycle
   a_sample_on: assert property (p_sample_on)
      else $error("valve shut");

   property p_hold_off;
      s_q.step == rms_pkg::ST_HOLD && is_auto ##1
         s_q.step == rms_pkg::ST_HOLD
         |-> !relay_o;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("valve open");

   property p_low_wait;
      s_q.step == rms_pkg::ST_HOLD && s_q.rem == 16'h0000 && rd < s_q.sp
         && is_auto && s_q.mode == rms_pkg::RMS_ISAMP
         && s_d.mode == rms_pkg::RMS_ISAMP
         |=> s_q.step == rms_pkg::ST_WAIT && s_q.rem == $past(s_q.wt);
   endproperty
   a_low_wait: assert property (p_low_wait) else $error("no wait");

   property p_repeat;
      (s_q.step == rms_pkg::ST_BLOW || s_q.step == rms_pkg::ST_WAIT) &&
         s_q.rem == 16'h0000 && is_auto && s_d.mode == rms_pkg::RMS_ISAMP
         && s_q.mode == rms_pkg::RMS_ISAMP
         |=> s_q.step == rms_pkg::ST_SAMPLE;
   endproperty
   a_repeat: assert property (p_repeat) else $error("no resample");

   property p_limit;
      s_q.step == rms_pkg::ST_FREE && s_q.lim != 16'h0000 &&
         s_q.lcnt >= s_q.lim && is_auto && s_d.mode == rms_pkg::RMS_ISAMP
         && s_q.mode == rms_pkg::RMS_ISAMP
         |=> s_q.step == rms_pkg::ST_WAIT ##1 !relay_o;
   endproperty
   a_limit: assert property (p_limit) else $error("limit ignored");

   property p_claim;
      s_q.mode == rms_pkg::RMS_ISAMP && claim_i && !bus_i.we &&
         claim_sensor_i == s_q.sel |=> s_q.mode == rms_pkg::RMS_OFF;
   endproperty
   a_claim: assert property (p_claim) else $error("claim ignored");

   property p_man_on;
      s_q.mode == rms_pkg::RMS_MANUAL && s_q.ond == 16'h0000 && want
         && !relay_o |=> relay_o;
   endproperty
   a_man_on: assert property (p_man_on) else $error("on delayed");

   property p_man_off;
      s_q.mode == rms_pkg::RMS_MANUAL && s_q.offd == 16'h0000 && !want
         && relay_o |=> !relay_o;
   endproperty
   a_man_off: assert property (p_man_off) else $error("off delayed");

   c_blow: cover property (s_q.step == rms_pkg::ST_BLOW ##1
      s_q.step == rms_pkg::ST_SAMPLE);
   c_free: cover property (s_q.step == rms_pkg::ST_FREE ##1
      s_q.step == rms_pkg::ST_WAIT);
   c_tp: cover property (s_q.mode == rms_pkg::RMS_TPROP && relay_o ##1
      !relay_o);
   c_man: cover property (s_q.mode == rms_pkg::RMS_MANUAL && $rose(relay_o));

endmodule

`default_nettype wire

/* rms_pkg.sv */
/*
 Shared constants and types for the relay mode sequencer: register
 offsets, reset values, mode and step encodings, bus and status carriers.
 Assumes a single 200 MHz clock and a plain register port master.
*/
`default_nettype none

package rms_pkg;

   // ------------------------------------------------------------
   // Widths and timing
   // ------------------------------------------------------------
   localparam int RMS_TW = 16;
   localparam longint RMS_CLK_HZ = 200_000_000;
   localparam int RMS_TICK_S = 1; // Time base unit, seconds
   localparam int RMS_TICK_CYCLES = int'(RMS_CLK_HZ * RMS_TICK_S);
   localparam logic [6:0] RMS_PCT_FULL = 7'h64;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] RMS_A_CTRL = 8'h00;
   localparam logic [7:0] RMS_A_SETPT = 8'h04;
   localparam logic [7:0] RMS_A_PBAND = 8'h08;
   localparam logic [7:0] RMS_A_DBAND = 8'h0C;
   localparam logic [7:0] RMS_A_PERIOD = 8'h10;
   localparam logic [7:0] RMS_A_SAMPLE = 8'h14;
   localparam logic [7:0] RMS_A_HOLD = 8'h18;
   localparam logic [7:0] RMS_A_MAXBD = 8'h1C;
   localparam logic [7:0] RMS_A_WAIT = 8'h20;
   localparam logic [7:0] RMS_A_LIMIT = 8'h24;
   localparam logic [7:0] RMS_A_ONDLY = 8'h28;
   localparam logic [7:0] RMS_A_OFFDLY = 8'h2C;
   localparam logic [7:0] RMS_A_STATUS = 8'h30;
   localparam logic [7:0] RMS_A_POS = 8'h34;
   localparam logic [7:0] RMS_A_REMAIN = 8'h38;

   // ------------------------------------------------------------
   // Encodings and carriers
   // ------------------------------------------------------------
   typedef enum logic [1:0] {RMS_OFF, RMS_TPROP, RMS_ISAMP, RMS_MANUAL}
      rms_mode_e;
   typedef enum logic [1:0] {RMS_HOA_OFF, RMS_HOA_HAND, RMS_HOA_AUTO}
      rms_hoa_e;
   typedef enum logic [2:0] {ST_IDLE, ST_SAMPLE, ST_HOLD, ST_BLOW,
      ST_WAIT, ST_FREE} rms_step_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } rms_bus_s;

   typedef struct packed {
      logic [6:0] pct;
      logic [15:0] pos;
      rms_step_e step;
      logic [15:0] remain;
   } rms_status_s;

   localparam rms_mode_e RMS_RST_MODE = RMS_OFF;

endpackage

`default_nettype wire

/* rms_plant_model.sv */
/*
 Partner model: blowdown valve on the relay plus a conductivity sensor.
 Assumes the relay output drives the valve directly, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module rms_plant_model (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic valve_i,
   input wire logic load_i,
   input wire logic [15:0] level_i,
   input wire logic responsive_i,
   output logic [15:0] sensor_o
);
   // ------------------------------------------------------------
   // Water chemistry
   // ------------------------------------------------------------
   // An open valve flushes and the reading falls one count a cycle; a dead
   // sensor (responsive low) never moves, so only a time limit can end it
   always_ff @(posedge ref_clk_i or posedge rst_i)
      if (rst_i)
         sensor_o <= 16'h0000;
      else if (load_i)
         sensor_o <= level_i;
      else if (valve_i && responsive_i && sensor_o != 16'h0000)
         sensor_o <= sensor_o - 16'h0001;
endmodule

`default_nettype wire

/* tb_relay_control_mode_sequencer.sv */
/*
 Self-checking bench for the relay mode sequencer with a valve model.
 Assumes TICK_CYCLES of 4, so one second is four clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_relay_control_mode_sequencer;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   rms_pkg::rms_bus_s bus = '0;
   logic [31:0] rd_data;
   logic [15:0] sens0;
   logic [1:0] sel = 2'h2;
   logic link = 1'b0;
   logic claim = 1'b0;
   logic claim_sens = 1'b0;
   logic relay;
   rms_pkg::rms_status_s status;
   logic load = 1'b0;
   logic [15:0] level = 16'h0000;
   logic resp = 1'b0;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [31:0] d;
   int n;
   // Time proportional rows: direction bit, reading, expected percent
   logic [7:0] t_dir = 8'h3F;
   logic [15:0] t_rd [8] = '{16'h03E8, 16'h041A, 16'h0401, 16'h044C,
      16'h04B0, 16'h0384, 16'h0384, 16'h03B6};
   logic [6:0] t_pct [8] = '{7'h00, 7'h32, 7'h19, 7'h64, 7'h64, 7'h00,
      7'h64, 7'h32};

   rms_relay_seq #(.TICK_CYCLES(4)) dut (.ref_clk_i(ref_clk_i),
      .rst_i(rst_i), .bus_i(bus), .rd_data_o(rd_data), .sensor0_i(sens0),
      .sensor1_i(16'h0000), .hand_off_auto_selector_i(sel),
      .link_activate_i(link), .claim_i(claim),
      .claim_sensor_i(claim_sens), .relay_o(relay), .status_o(status));

   rms_plant_model plant (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .valve_i(relay), .load_i(load), .level_i(level),
      .responsive_i(resp), .sensor_o(sens0));

   // ------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ------------------------------------------------------------
   always #2.5 ref_clk_i = ~ref_clk_i;

   // Hang guard, well above the roughly 1200 cycles the run needs
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (bad_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk_i);
      bus <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
      @(posedge ref_clk_i);
      bus.we <= 1'b0;
   endtask

   // Read data is valid only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk_i);
      bus <= '{addr: a, wdata: 32'h0000_0000, we: 1'b0, re: 1'b1};
      @(posedge ref_clk_i);
      bus.re <= 1'b0;
      #1;
      d = rd_data;
   endtask

   task automatic setlvl(input logic [15:0] v);
      @(posedge ref_clk_i);
      load <= 1'b1;
      level <= v;
      @(posedge ref_clk_i);
      load <= 1'b0;
   endtask

   // Bounded wait for a sequencer step, then compare it
   task automatic wstep(input rms_pkg::rms_step_e s, input int lim);
      int k;
      k = 0;
      while (status.step !== s && k < lim)
      begin
         cyc(1);
         k++;
      end
      chk(32'(status.step), 32'(s));
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      cyc(1);
      chk(32'({relay, status.pct, status.step, status.remain}), 32'h0);
      chk(32'(status.pos), 32'h0);
      rd(8'h3C);
      chk(d, 32'h0000_0000);
      wr(rms_pkg::RMS_A_STATUS, 32'hFFFF_FFFF);
      rd(rms_pkg::RMS_A_STATUS);
      chk(d, 32'h0000_0000);
      wr(rms_pkg::RMS_A_PBAND, 32'hFFFF_0064);
      rd(rms_pkg::RMS_A_PBAND);
      chk(d, 32'h0000_0064);
      wr(rms_pkg::RMS_A_SETPT, 32'h0000_03E8);
      wr(rms_pkg::RMS_A_PERIOD, 32'h0000_0004);
      // Table of time proportional cases, relay counted over 4 periods
      for (int i = 0; i < 8; i++)
      begin
         wr(rms_pkg::RMS_A_CTRL, 32'h0000_0000);
         setlvl(t_rd[i]);
         wr(rms_pkg::RMS_A_CTRL, {29'h0, t_dir[i], 2'h1});
         cyc(24);
         chk(32'(status.pct), 32'(t_pct[i]));
         n = 0;
         repeat (64)
         begin
            cyc(1);
            n += int'(relay);
         end
         chk(n, (int'(t_pct[i]) * 4 + 99) / 100 * 16);
      end
      rd(rms_pkg::RMS_A_POS);
      chk(32'(d < 32'h0000_0004), 32'h1);
      // Sampling refused while the hvac enable is clear: time prop stays
      wr(rms_pkg::RMS_A_CTRL, 32'h0000_000A);
      rd(rms_pkg::RMS_A_CTRL);
      chk(d, 32'h0000_0009);
      // Trapped sample, reading 1050: blowdown of half of 10 s
      wr(rms_pkg::RMS_A_SAMPLE, 32'h0000_0002);
      wr(rms_pkg::RMS_A_HOLD, 32'h0000_0001);
      wr(rms_pkg::RMS_A_MAXBD, 32'h0000_000A);
      wr(rms_pkg::RMS_A_WAIT, 32'h0000_0003);
      setlvl(16'h041A);
      wr(rms_pkg::RMS_A_CTRL, 32'h0000_001A);
      wstep(rms_pkg::ST_SAMPLE, 40);
      cyc(2);
      chk(relay, 1'b1);
      wstep(rms_pkg::ST_HOLD, 40);
      cyc(2);
      chk(relay, 1'b0);
      wstep(rms_pkg::ST_BLOW, 40);
      chk(32'(status.remain), 32'h5);
      n = 0;
      while (status.step === rms_pkg::ST_BLOW && n < 100)
      begin
         cyc(1);
         n += int'(relay);
      end
      chk(32'(n >= 16 && n <= 24), 32'h1);
      chk(32'(status.step), 32'(rms_pkg::ST_SAMPLE));
      // Trapped reading below set point waits instead of blowing down
      setlvl(16'h0384);
      wstep(rms_pkg::ST_WAIT, 80);
      chk(32'(status.remain), 32'h3);
      cyc(2);
      chk(relay, 1'b0);
      wstep(rms_pkg::ST_SAMPLE, 24);
      // Untrapped: valve stays open until reading clears the deadband
      wr(rms_pkg::RMS_A_CTRL, 32'h0000_0000);
      wr(rms_pkg::RMS_A_DBAND, 32'h0000_0014);
      setlvl(16'h044C);
      resp <= 1'b1;
      wr(rms_pkg::RMS_A_CTRL, 32'h0000_0012);
      wstep(rms_pkg::ST_FREE, 60);
      cyc(2);
      chk(relay, 1'b1);
      wstep(rms_pkg::ST_WAIT, 400);
      chk(32'(sens0 < 16'h03D4), 32'h1);
      // Dead sensor: a 3 s output limit ends the open valve
      wr(rms_pkg::RMS_A_CTRL, 32'h0000_0000);
      resp <= 1'b0;
      setlvl(16'h044C);
      wr(rms_pkg::RMS_A_LIMIT, 32'h0000_0003);
      wr(rms_pkg::RMS_A_CTRL, 32'h0000_0012);
      wstep(rms_pkg::ST_FREE, 60);
      n = 0;
      while (status.step === rms_pkg::ST_FREE && n < 100)
      begin
         cyc(1);
         n++;
      end
      chk(32'(n >= 8 && n <= 16), 32'h1);
      chk(32'(status.step), 32'(rms_pkg::ST_WAIT));
      // A claim on the other sensor leaves us alone, on ours forces off
      @(posedge ref_clk_i)
      begin
         claim <= 1'b1;
         claim_sens <= 1'b1;
      end
      @(posedge ref_clk_i) claim <= 1'b0;
      rd(rms_pkg::RMS_A_CTRL);
      chk(d[1:0], 2'h2);
      @(posedge ref_clk_i)
      begin
         claim <= 1'b1;
         claim_sens <= 1'b0;
      end
      @(posedge ref_clk_i) claim <= 1'b0;
      rd(rms_pkg::RMS_A_CTRL);
      chk(d[1:0], 2'h0);
      chk(relay, 1'b0);
      // Manual: linked request with a 2 s on delay, immediate off
      sel <= 2'h0;
      wr(rms_pkg::RMS_A_ONDLY, 32'h0000_0002);
      wr(rms_pkg::RMS_A_CTRL, 32'h0000_0003);
      @(posedge ref_clk_i) link <= 1'b1;
      cyc(3);
      chk(relay, 1'b0);
      cyc(12);
      chk(relay, 1'b1);
      @(posedge ref_clk_i) link <= 1'b0;
      cyc(2);
      chk(relay, 1'b0);
      // Hand selector with no on delay and a 2 s off delay
      wr(rms_pkg::RMS_A_ONDLY, 32'h0000_0000);
      wr(rms_pkg::RMS_A_OFFDLY, 32'h0000_0002);
      @(posedge ref_clk_i) sel <= 2'h1;
      cyc(2);
      chk(relay, 1'b1);
      @(posedge ref_clk_i) sel <= 2'h0;
      cyc(3);
      chk(relay, 1'b1);
      cyc(12);
      chk(relay, 1'b0);
      end_of_test();
   end
endmodule

`default_nettype wire
